// ===== rtl/mdps_pkg.sv
// shared timing constants for the protection sequencer
package mdps_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 10;              // 100 MHz ref_clk

  // glitch masks for the current limit and overcurrent comparators
  localparam int unsigned LIMIT_BLANK_NS = 3000;           // limit_blanking_time
  localparam int unsigned OC_BLANK_NS    = 3000;           // overcurrent_blanking_time
  // least times, so round up
  localparam int unsigned LIMIT_BLANK_CYC = (LIMIT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OC_BLANK_CYC    = (OC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // capacitor timebase: period = 0.313 * C * 1e6 s, i.e. 313000 ns per nF
  localparam longint TIMEBASE_NS_PER_NF = 313000;
  // 31.5 timebase periods, kept as 63 half periods
  localparam longint TB_HALF_PERIODS    = 63;
  localparam longint RESTART_CAP_NF     = 1000;            // default restart capacitor
  localparam longint RAMP_CAP_NF        = 10;              // default ramp_cap_pin capacitor
  localparam longint RESTART_CYC_L = RESTART_CAP_NF * TIMEBASE_NS_PER_NF * TB_HALF_PERIODS
                                     / (2 * CLK_PERIOD_NS);
  localparam longint RAMP_CYC_L    = RAMP_CAP_NF * TIMEBASE_NS_PER_NF * TB_HALF_PERIODS
                                     / (2 * CLK_PERIOD_NS);
  localparam int unsigned RESTART_CYC_DEF = int'(RESTART_CYC_L);
  localparam int unsigned RAMP_CYC_DEF    = int'(RAMP_CYC_L);

  // duty ramp: full-scale rise takes the ramp time
  localparam int unsigned DUTY_W_DEF        = 8;
  localparam int unsigned RAMP_STEP_CYC_DEF = RAMP_CYC_DEF / (1 << DUTY_W_DEF);

  // wait after undervoltage release, shortest for a stopped motor
  localparam longint UV_WAIT_SHORT_NS = 20000000;          // 0.02 s
  localparam longint UV_WAIT_LONG_NS  = 340000000;         // 0.34 s
  localparam int unsigned UV_WAIT_SHORT_DEF = int'(UV_WAIT_SHORT_NS / CLK_PERIOD_NS);
  localparam int unsigned UV_WAIT_LONG_DEF  = int'(UV_WAIT_LONG_NS / CLK_PERIOD_NS);

  // flag synchroniser layout
  localparam int unsigned SYNC_W   = 11;
  localparam int unsigned SY_LIMIT = 0;
  localparam int unsigned SY_OC_LO = 1;
  localparam int unsigned SY_OC_HI = 6;
  localparam int unsigned SY_THERM = 7;
  localparam int unsigned SY_VM    = 8;
  localparam int unsigned SY_REGULATOR_SUPPLY  = 9;
  localparam int unsigned SY_SPIN  = 10;

  // protection states
  typedef enum logic [2:0] {
    ST_UVHOLD,
    ST_UVWAIT,
    ST_RUN,
    ST_OCTRIP,
    ST_THTRIP,
    ST_RESTART
  } mdps_state_t;

endpackage

// ===== rtl/mdps_protection_sequencer.sv
// Contract
// - limit cuts high side, low side untouched
// - high side returns on next pwm rise
// - limit from sense comparator over threshold
// - mask limit pulses shorter than 3 us
// - six overcurrent flags combine into one
// - any flag held 3 us trips all off
// - resume after flags clear plus restart delay
// - restart delay is 31.5 timebase periods
// - duty rises gradually toward command
// - ramp time set by ramp capacitor timebase
// - over-temperature turns all outputs off
// - resume after temperature clears plus delay
// - motor supply low resets and disables
// - regulator supply low resets and disables
// - motor dependent wait after undervoltage release
`timescale 1ns/100ps
`default_nettype none

module mdps_protection_sequencer #(
  parameter int unsigned RESTART_CYC   = mdps_pkg::RESTART_CYC_DEF,
  parameter int unsigned RAMP_STEP_CYC = mdps_pkg::RAMP_STEP_CYC_DEF,
  parameter int unsigned UV_WAIT_SHORT = mdps_pkg::UV_WAIT_SHORT_DEF,
  parameter int unsigned UV_WAIT_LONG  = mdps_pkg::UV_WAIT_LONG_DEF,
  parameter int unsigned DUTY_W        = mdps_pkg::DUTY_W_DEF
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // comparator flags, asynchronous
  input  wire logic              limitSense,
  input  wire logic [5:0]        overcurrentFlag,
  input  wire logic              thermalFlag,
  input  wire logic              motorSupplyLow,
  input  wire logic              regulatorSupplyLow,
  input  wire logic              motorSpinning,
  // internal pwm, commutation and duty, same clock
  input  wire logic              pwmIn,
  input  wire logic [2:0]        hsCmd,
  input  wire logic [2:0]        lsCmd,
  input  wire logic [DUTY_W-1:0] dutyCommand,
  // power stage side
  output logic      [2:0]        hsGate,
  output logic      [2:0]        lsGate,
  output logic                   outputEnable,
  output logic                   logicReset,
  output logic                   limitActive,
  output logic      [DUTY_W-1:0] dutyOut
);

  localparam int unsigned LIM_W = $clog2(mdps_pkg::LIMIT_BLANK_CYC + 1);
  localparam int unsigned OC_W  = $clog2(mdps_pkg::OC_BLANK_CYC + 1);
  localparam logic [LIM_W-1:0] LIM_FULL  = LIM_W'(mdps_pkg::LIMIT_BLANK_CYC);
  localparam logic [OC_W-1:0]  OC_FULL   = OC_W'(mdps_pkg::OC_BLANK_CYC);
  localparam logic [31:0] RESTART_LAST   = 32'(RESTART_CYC - 1);
  localparam logic [31:0] STEP_LAST      = 32'(RAMP_STEP_CYC - 1);
  localparam logic [31:0] WAIT_SHORT_LST = 32'(UV_WAIT_SHORT - 1);
  localparam logic [31:0] WAIT_LONG_LST  = 32'(UV_WAIT_LONG - 1);

  ////////////////////////////////////////////////////////////////////////////
  // flag synchroniser
  logic [mdps_pkg::SYNC_W-1:0] syncA;  // first stage, read only by syncB
  logic [mdps_pkg::SYNC_W-1:0] syncB;  // settled flags
  logic                        limS;
  logic [5:0]                  ocS;
  logic                        thS;
  logic                        uv;
  logic                        spinS;

  // two flops per comparator; flags are slow, so no bus coherence needed
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      syncA <= '0;
      syncB <= '0;
    end
    else
    begin
      syncA <= {motorSpinning, regulatorSupplyLow, motorSupplyLow,
                thermalFlag, overcurrentFlag, limitSense};
      syncB <= syncA;
    end
  end

  assign limS  = syncB[mdps_pkg::SY_LIMIT];
  assign ocS   = syncB[mdps_pkg::SY_OC_HI:mdps_pkg::SY_OC_LO];
  assign thS   = syncB[mdps_pkg::SY_THERM];
  // either supply low forces lockout
  assign uv    = syncB[mdps_pkg::SY_VM] | syncB[mdps_pkg::SY_REGULATOR_SUPPLY];
  assign spinS = syncB[mdps_pkg::SY_SPIN];

  ////////////////////////////////////////////////////////////////////////////
  // current limiter
  logic [LIM_W-1:0] limCnt;       // cycles the limit flag has stood
  logic [LIM_W-1:0] next_limCnt;
  logic             limQual;      // limit held past the mask
  logic             hsCut;        // high side held off
  logic             next_hsCut;
  logic             pwmPrev;
  logic             pwmRise;      // on-phase start

  assign limQual = limS && (limCnt == LIM_FULL);
  assign pwmRise = pwmIn && !pwmPrev;

  // saturating mask counter, cleared by any low sample
  always_comb
  begin
    next_limCnt = '0;
    next_hsCut  = hsCut;
    if (limS)
    begin
      next_limCnt = (limCnt == LIM_FULL) ? limCnt : limCnt + LIM_W'(1);
    end
    if (logicReset)
    begin
      next_hsCut = 1'b0;
    end
    else if (limQual)
    begin
      // set wins over a pwm rise in the same cycle
      next_hsCut = 1'b1;
    end
    else if (pwmRise)
    begin
      next_hsCut = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      limCnt  <= '0;
      hsCut   <= 1'b0;
      pwmPrev <= 1'b0;
    end
    else
    begin
      limCnt  <= next_limCnt;
      hsCut   <= next_hsCut;
      pwmPrev <= pwmIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overcurrent masks, one per transistor
  logic [OC_W-1:0] ocCnt [6];  // per-flag hold counters
  logic [5:0]      ocQual;     // flag held past the mask
  logic            ocLong;     // any flag qualified
  logic            ocAny;      // any flag present at all

  for (genvar g = 0; g < 6; g++)
  begin : g_oc
    logic [OC_W-1:0] next_ocCnt;
    // each flag must itself stay high; two alternating flags do not add up
    always_comb
    begin
      next_ocCnt = '0;
      if (ocS[g])
      begin
        next_ocCnt = (ocCnt[g] == OC_FULL) ? ocCnt[g] : ocCnt[g] + OC_W'(1);
      end
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
      begin
        ocCnt[g] <= '0;
      end
      else
      begin
        ocCnt[g] <= next_ocCnt;
      end
    end
    assign ocQual[g] = ocS[g] && (ocCnt[g] == OC_FULL);
  end

  assign ocLong = |ocQual;
  assign ocAny  = |ocS;

  ////////////////////////////////////////////////////////////////////////////
  // protection state machine
  mdps_pkg::mdps_state_t state;
  mdps_pkg::mdps_state_t next_state;
  logic [31:0]           tmr;        // restart and release wait timer
  logic [31:0]           next_tmr;
  logic [31:0]           waitLast;   // last count of the release wait

  // a stopped motor needs only the short wait
  assign waitLast = spinS ? WAIT_LONG_LST : WAIT_SHORT_LST;

  always_comb
  begin
    next_state = state;
    next_tmr   = tmr;
    if (uv)
    begin
      // lockout overrides every other state
      next_state = mdps_pkg::ST_UVHOLD;
      next_tmr   = '0;
    end
    else
    begin
      unique case (state)
        mdps_pkg::ST_UVHOLD:
        begin
          next_state = mdps_pkg::ST_UVWAIT;
          next_tmr   = '0;
        end
        mdps_pkg::ST_UVWAIT:
        begin
          if (tmr >= waitLast)
          begin
            next_state = mdps_pkg::ST_RUN;
            next_tmr   = '0;
          end
          else
          begin
            next_tmr = tmr + 32'h1;
          end
        end
        mdps_pkg::ST_RUN:
        begin
          if (ocLong)
          begin
            next_state = mdps_pkg::ST_OCTRIP;
          end
          else if (thS)
          begin
            next_state = mdps_pkg::ST_THTRIP;
          end
        end
        mdps_pkg::ST_OCTRIP:
        begin
          // delay starts only once every flag is clear
          if (!ocAny)
          begin
            next_state = mdps_pkg::ST_RESTART;
            next_tmr   = '0;
          end
        end
        mdps_pkg::ST_THTRIP:
        begin
          if (!thS)
          begin
            next_state = mdps_pkg::ST_RESTART;
            next_tmr   = '0;
          end
        end
        mdps_pkg::ST_RESTART:
        begin
          // a returning fault sends us back; the delay then starts over
          if (thS)
          begin
            next_state = mdps_pkg::ST_THTRIP;
          end
          else if (ocAny)
          begin
            next_state = mdps_pkg::ST_OCTRIP;
          end
          else if (tmr == RESTART_LAST)
          begin
            next_state = mdps_pkg::ST_RUN;
            next_tmr   = '0;
          end
          else
          begin
            next_tmr = tmr + 32'h1;
          end
        end
        default:
        begin
          next_state = mdps_pkg::ST_UVHOLD;
          next_tmr   = '0;
        end
      endcase
    end
  end

  // start in lockout so a power-up always runs the release wait
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= mdps_pkg::ST_UVHOLD;
      tmr   <= '0;
    end
    else
    begin
      state <= next_state;
      tmr   <= next_tmr;
    end
  end

  assign outputEnable = (state == mdps_pkg::ST_RUN);
  assign logicReset   = (state == mdps_pkg::ST_UVHOLD) || (state == mdps_pkg::ST_UVWAIT);
  assign limitActive  = hsCut;
  // low side keeps commutating under limit; all six off when disabled
  assign hsGate = outputEnable ? (hsCmd & ~{3{hsCut}}) : 3'h0;
  assign lsGate = outputEnable ? lsCmd : 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // soft duty ramp
  logic [31:0]       stepCnt;       // cycles since the last duty step
  logic [31:0]       next_stepCnt;
  logic [DUTY_W-1:0] next_dutyOut;

  // falls follow at once; only rises are paced, so a restart is soft too
  always_comb
  begin
    next_stepCnt = '0;
    next_dutyOut = dutyOut;
    if (!outputEnable)
    begin
      next_dutyOut = '0;
    end
    else if (dutyCommand < dutyOut)
    begin
      next_dutyOut = dutyCommand;
    end
    else if (dutyCommand > dutyOut)
    begin
      if (stepCnt >= STEP_LAST)
      begin
        next_dutyOut = dutyOut + DUTY_W'(1);
      end
      else
      begin
        next_stepCnt = stepCnt + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stepCnt <= '0;
      dutyOut <= '0;
    end
    else
    begin
      stepCnt <= next_stepCnt;
      dutyOut <= next_dutyOut;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_restartDone;
    state == mdps_pkg::ST_RESTART && !uv && !thS && !ocAny && tmr == RESTART_LAST;
  endsequence

  sequence s_faultBack;
    state == mdps_pkg::ST_RESTART && !uv && (thS || ocAny);
  endsequence

  a_hs_cut: assert property (hsCut |-> hsGate == 3'h0)
    else $error("high side on during current limit");
  a_ls_kept: assert property (outputEnable |-> lsGate == lsCmd)
    else $error("low side disturbed while enabled");
  a_hs_rearm: assert property ($fell(hsCut) |-> $past(pwmRise) || $past(logicReset))
    else $error("high side released without pwm rise");
  a_limit_src: assert property ($rose(hsCut) |-> $past(limS, 1) && $past(limS, 8))
    else $error("limit set without sense flag");
  a_limit_blank: assert property ($rose(limS) |-> (!limQual)[*8])
    else $error("limit taken inside mask");
  a_oc_trip: assert property (state == mdps_pkg::ST_RUN && ocLong && !uv
                              |=> !outputEnable && lsGate == 3'h0)
    else $error("overcurrent did not disable outputs");
  a_oc_hold: assert property (state == mdps_pkg::ST_OCTRIP && ocAny && !uv
                              |=> state == mdps_pkg::ST_OCTRIP)
    else $error("left overcurrent with flag present");
  a_restart_len: assert property (s_restartDone |=> outputEnable ##0 tmr == 32'h0)
    else $error("restart delay end not honoured");
  a_restart_early: assert property ($rose(outputEnable)
                                    && $past(state) == mdps_pkg::ST_RESTART
                                    |-> $past(tmr) == RESTART_LAST)
    else $error("restart delay cut short");
  a_fault_back: assert property (s_faultBack |=> !outputEnable ##1 !outputEnable)
    else $error("fault in delay did not hold outputs off");
  a_ramp_step: assert property (dutyOut > $past(dutyOut)
                                |-> dutyOut == $past(dutyOut) + DUTY_W'(1))
    else $error("duty stepped by more than one");
  a_th_off: assert property (state == mdps_pkg::ST_RUN && thS && !uv
                             |=> !outputEnable)
    else $error("thermal did not disable outputs");
  a_th_hold: assert property (state == mdps_pkg::ST_THTRIP && thS && !uv
                              |=> state == mdps_pkg::ST_THTRIP)
    else $error("left thermal trip while hot");
  a_uv_prio: assert property (uv |=> logicReset && hsGate == 3'h0 && lsGate == 3'h0)
    else $error("undervoltage did not lock out");
  a_uv_wait: assert property ($rose(outputEnable) && $past(state) == mdps_pkg::ST_UVWAIT
                              |-> $past(tmr) >= $past(waitLast))
    else $error("release wait cut short");

endmodule

`default_nettype wire

// ===== testbench/mdps_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// power stage and motor as the gate drivers see them
module mdps_stage_model #(
  parameter int unsigned COAST = 1000  // cycles the rotor turns on unpowered
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // gate drive from the sequencer
  input  wire logic [2:0] hsGate,
  input  wire logic [2:0] lsGate,
  // faults ordered by the bench
  input  wire logic       limitReq,
  input  wire logic [5:0] shortReq,
  // sensed back to the sequencer
  output logic            limitSense,
  output logic [5:0]      overcurrentFlag,
  output logic            motorSpinning
);
  int unsigned coastCnt;  // cycles left before the rotor stops

  // sense current only flows while a high side conducts, so a cut drops it
  assign limitSense = limitReq & (|hsGate);
  // a short only shows on a transistor that is switched on
  assign overcurrentFlag = shortReq & {lsGate, hsGate};
  assign motorSpinning = (coastCnt != 0);

  ////////////////////////////////////////////////////////////////////////
  // rotor coasts down once the bridge stops driving
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      coastCnt <= 0;
    else if (|{hsGate, lsGate})
      coastCnt <= COAST;
    else if (coastCnt != 0)
      coastCnt <= coastCnt - 1;
endmodule
`default_nettype wire

// ===== testbench/motor_driver_protection_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module motor_driver_protection_sequencer_tb;
  // short counts keep the run brief
  localparam int unsigned RC = 50;
  localparam int unsigned STEP = 4;
  localparam int unsigned WS = 20;
  localparam int unsigned WL = 40;

  logic ref_clk, rst, limitSense, thermalFlag, motorSupplyLow;
  logic regulatorSupplyLow, motorSpinning, pwmIn, limitReq;
  logic outputEnable, logicReset, limitActive;
  logic [5:0] overcurrentFlag, shortReq;
  logic [2:0] hsCmd, lsCmd, hsGate, lsGate;
  logic [7:0] dutyCommand, dutyOut, prev;
  int err_count, comparisons, n, bad, lo;

  mdps_protection_sequencer #(.RESTART_CYC(RC), .RAMP_STEP_CYC(STEP),
    .UV_WAIT_SHORT(WS), .UV_WAIT_LONG(WL), .DUTY_W(8)) dut (
    .ref_clk(ref_clk), .rst(rst), .limitSense(limitSense),
    .overcurrentFlag(overcurrentFlag), .thermalFlag(thermalFlag),
    .motorSupplyLow(motorSupplyLow), .regulatorSupplyLow(regulatorSupplyLow),
    .motorSpinning(motorSpinning), .pwmIn(pwmIn), .hsCmd(hsCmd), .lsCmd(lsCmd),
    .dutyCommand(dutyCommand), .hsGate(hsGate), .lsGate(lsGate),
    .outputEnable(outputEnable), .logicReset(logicReset),
    .limitActive(limitActive), .dutyOut(dutyOut));

  mdps_stage_model #(.COAST(1000)) stage (
    .ref_clk(ref_clk), .rst(rst), .hsGate(hsGate), .lsGate(lsGate),
    .limitReq(limitReq), .shortReq(shortReq), .limitSense(limitSense),
    .overcurrentFlag(overcurrentFlag), .motorSpinning(motorSpinning));

  ////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // inputs change 1 ns after the edge, clear of sampling
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // bounded wait for the bridge to come back, cycles counted
  task automatic wait_en(output int c);
    c = 0;
    while (outputEnable !== 1'b1 && c < 3000)
    begin
      tick(1);
      c++;
    end
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog, well beyond the expected few thousand cycles
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_count = 0;
    comparisons = 0;
    {rst, thermalFlag, motorSupplyLow, regulatorSupplyLow, pwmIn, limitReq} = 6'h20;
    {shortReq, hsCmd, lsCmd, dutyCommand} = '0;
    void'($urandom(84));
    tick(10);
    check("rst_lock", logicReset, 1);
    check("rst_oe", outputEnable, 0);
    rst = 1'b0;
    // power-up runs the release wait with the rotor still
    wait_en(n);
    check("up_wait", (n >= WS && n <= WS + 10), 1);
    check("up_lock", logicReset, 0);
    done("startup");

    // gates follow commutation while healthy
    repeat (16)
    begin
      hsCmd = 3'($urandom);
      lsCmd = 3'($urandom);
      tick(1);
      check("hs_follow", hsGate, hsCmd);
      check("ls_follow", lsGate, lsCmd);
    end
    done("gates");

    // limit: masked for 300 cycles, then high side cut until pwm rise
    hsCmd = 3'h7;
    lsCmd = 3'h2;
    limitReq = 1'b1;
    tick(290);
    check("lim_mask", limitActive, 0);
    tick(20);
    check("lim_on", limitActive, 1);
    check("lim_hs", hsGate, 3'h0);
    check("lim_ls", lsGate, 3'h2);
    limitReq = 1'b0;
    tick(10);
    check("lim_hold", limitActive, 1);
    pwmIn = 1'b1;
    tick(3);
    check("lim_clr", limitActive, 0);
    check("lim_hs_back", hsGate, 3'h7);
    pwmIn = 1'b0;
    done("limit");

    // duty ramp: at most one step per STEP cycles, ends at command
    dutyCommand = 8'($urandom_range(60, 20));
    bad = 0;
    prev = dutyOut;
    for (int i = 1; i <= dutyCommand * STEP + 8; i++)
    begin
      tick(1);
      if (dutyOut > prev + 1 || dutyOut > i / STEP + 1)
        bad++;
      prev = dutyOut;
    end
    check("ramp_rate", bad, 0);
    check("ramp_end", dutyOut, dutyCommand);
    dutyCommand = 8'h3;
    tick(2);
    check("ramp_fall", dutyOut, 8'h3);
    done("ramp");

    // overcurrent on each transistor in turn
    lsCmd = 3'h7;
    for (int k = 0; k < 6; k++)
    begin
      shortReq = 6'h1 << k;
      tick(100);
      shortReq = 6'h0;
      tick(5);
      check("oc_short", outputEnable, 1);
      shortReq = 6'h1 << k;
      // flag seen 2 edges late, then 301 samples: trip lands on edge 303
      tick(300);
      check("oc_mask", outputEnable, 1);
      // the cut gates drop the flag, so the delay runs from about edge 306
      tick(4);
      check("oc_trip", outputEnable, 0);
      check("oc_gates", {hsGate, lsGate}, 6'h0);
      shortReq = 6'h0;
      wait_en(n);
      check("oc_delay", (n >= RC && n <= RC + 10), 1);
      check("oc_soft", dutyOut, 0);
    end
    done("overcurrent");

    // thermal trip, with a repeat during the restart delay
    thermalFlag = 1'b1;
    tick(4);
    check("th_trip", outputEnable, 0);
    check("th_gates", {hsGate, lsGate}, 6'h0);
    thermalFlag = 1'b0;
    tick(20);
    check("th_wait", outputEnable, 0);
    thermalFlag = 1'b1;
    tick(3);
    thermalFlag = 1'b0;
    wait_en(n);
    check("th_restart", (n >= RC && n <= RC + 10), 1);
    done("thermal");

    // lockouts: motor supply while spinning, regulator with a stopped rotor
    for (int s = 0; s < 2; s++)
    begin
      motorSupplyLow = (s == 0);
      regulatorSupplyLow = (s == 1);
      thermalFlag = (s == 1);
      tick(s == 0 ? 10 : 1100);
      check("uv_lock", logicReset, 1);
      check("uv_oe", {outputEnable, limitActive}, 2'h0);
      check("uv_gates", {hsGate, lsGate}, 6'h0);
      {motorSupplyLow, regulatorSupplyLow, thermalFlag} = 3'h0;
      lo = (s == 0) ? WL : WS;
      wait_en(n);
      check("uv_wait", (n >= lo && n <= lo + 10), 1);
    end
    done("lockout");
    end_sim();
  end
endmodule
`default_nettype wire
